// ---- core/ssd_pkg.sv ----
// package for the start/stop command decoder: selections, commands, reset values
// assumes a single clock domain; no register bus, all settings are ports
`default_nettype none
package ssd_pkg;

  // -------------------------------------------------------------------------
  // command source selection codes
  // -------------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    SSD_SEL_NONE = 3'h0,
    SSD_SEL_START_ONLY = 3'h1,
    SSD_SEL_START_DIR = 3'h2,
    SSD_SEL_FWD_REV = 3'h3,
    SSD_SEL_PULSE_HOLD = 3'h4
  } ssd_sel_t;

  // -------------------------------------------------------------------------
  // decoded command
  // -------------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SSD_CMD_STOP = 2'h0,
    SSD_CMD_START_FWD = 2'h1,
    SSD_CMD_START_REV = 2'h2
  } ssd_cmd_t;

  typedef struct packed
  {
    logic src_one;
    logic src_two;
  } ssd_src_t;

  typedef struct packed
  {
    ssd_cmd_t cmd;
    logic keys_disabled;
  } ssd_out_t;

  localparam logic SSD_TRIG_EDGE = 1'h0;
  localparam logic SSD_TRIG_LEVEL = 1'h1;
  localparam ssd_cmd_t SSD_CMD_RESET = SSD_CMD_STOP;
  localparam logic SSD_KEYS_DIS_RESET = 1'h0;
  localparam ssd_src_t SSD_SRC_RESET = 2'h0;

endpackage
`default_nettype wire

// ---- core/ssd_sync.sv ----
// two flip-flop synchroniser for the command source pins
// assumes pins are asynchronous to clock
`timescale 1ns/100ps
`default_nettype none
module ssd_sync
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clock_en,
  input wire ssd_pkg::ssd_src_t pin_in,
  output var ssd_pkg::ssd_src_t sync_out
);
  import ssd_pkg::*;

  ssd_src_t stage_one;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage_one <= SSD_SRC_RESET;
      sync_out <= SSD_SRC_RESET;
    end
    else if (clock_en)
    begin
      stage_one <= pin_in;
      sync_out <= stage_one;
    end
  end
endmodule
`default_nettype wire

// ---- core/ssd_decoder.sv ----
// start/stop decoder for external location one; command to drive run logic
// assumes source pins asynchronous, settings quasi-static from same clock
`timescale 1ns/100ps
`default_nettype none
module ssd_decoder
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clock_en,
  input wire ssd_pkg::ssd_sel_t sel,
  input wire logic trig_level,
  input wire ssd_pkg::ssd_src_t src_pins,
  output var ssd_pkg::ssd_out_t dec_out
);
  import ssd_pkg::*;

  // -------------------------------------------------------------------------
  // input capture
  // -------------------------------------------------------------------------
  ssd_src_t src;
  ssd_src_t src_prev;
  ssd_cmd_t next_cmd;
  logic next_keys_dis;
  logic rise_one;
  logic cond_one;
  logic cond_two;

  // pins are asynchronous: two stages cost two cycles of latency but keep
  // a metastable level away from the edge detect and the decode
  ssd_sync u_sync
  (
    .clock(clock),
    .rst_b(rst_b),
    .clock_en(clock_en),
    .pin_in(src_pins),
    .sync_out(src)
  );

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      src_prev <= SSD_SRC_RESET;
    else if (clock_en)
      src_prev <= src;
  end

  // start condition for one bit under the trigger setting
  function automatic logic start_cond(input logic now, input logic last, input logic lvl);
    start_cond = (lvl == SSD_TRIG_LEVEL) ? now : (now && !last);
  endfunction

  assign rise_one = start_cond(src.src_one, src_prev.src_one, SSD_TRIG_EDGE);
  assign cond_one = start_cond(src.src_one, src_prev.src_one, trig_level);
  assign cond_two = start_cond(src.src_two, src_prev.src_two, trig_level);

  // -------------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------------
  always_comb
  begin
    next_cmd = dec_out.cmd;
    next_keys_dis = 1'b0;
    unique case (sel)
      SSD_SEL_NONE:
        next_cmd = dec_out.cmd;
      SSD_SEL_START_ONLY:
      begin
        if (!src.src_one)
          next_cmd = SSD_CMD_STOP;
        else if (cond_one)
          next_cmd = SSD_CMD_START_FWD;
      end
      SSD_SEL_START_DIR:
      begin
        if (!src.src_one)
          next_cmd = SSD_CMD_STOP;
        else if (cond_one)
          next_cmd = src.src_two ? SSD_CMD_START_REV : SSD_CMD_START_FWD;
      end
      SSD_SEL_FWD_REV:
      begin
        if (src.src_one == src.src_two)
          next_cmd = SSD_CMD_STOP;
        else if (cond_one && !src.src_two)
          next_cmd = SSD_CMD_START_FWD;
        else if (cond_two && !src.src_one)
          next_cmd = SSD_CMD_START_REV;
      end
      SSD_SEL_PULSE_HOLD:
      begin
        // trigger setting deliberately unused here
        next_keys_dis = !src.src_two;
        if (!src.src_two)
          next_cmd = SSD_CMD_STOP;
        else if (rise_one)
          next_cmd = SSD_CMD_START_FWD;
      end
      default:
        // unused codes behave as no source selected
        next_cmd = dec_out.cmd;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dec_out.cmd <= SSD_CMD_RESET;
      dec_out.keys_disabled <= SSD_KEYS_DIS_RESET;
    end
    else if (clock_en)
    begin
      dec_out.cmd <= next_cmd;
      dec_out.keys_disabled <= next_keys_dis;
    end
  end

  // -------------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_sel4_two_low;
    clock_en && sel == SSD_SEL_PULSE_HOLD && !src.src_two;
  endsequence

  a_sel1_low_stop: assert property (
    clock_en && sel == SSD_SEL_START_ONLY && !src.src_one |=> dec_out.cmd == SSD_CMD_STOP)
    else $error("sel1 low source one did not stop");
  a_sel1_edge_start: assert property (
    clock_en && sel == SSD_SEL_START_ONLY && src.src_one && !src_prev.src_one
    |=> dec_out.cmd == SSD_CMD_START_FWD)
    else $error("sel1 rising source one did not start");
  a_sel2_direction: assert property (
    clock_en && sel == SSD_SEL_START_DIR && src.src_one && !src_prev.src_one
    |=> dec_out.cmd == ($past(src.src_two) ? SSD_CMD_START_REV : SSD_CMD_START_FWD))
    else $error("sel2 direction wrong");
  a_sel3_rev_start: assert property (
    clock_en && sel == SSD_SEL_FWD_REV && !src.src_one && src.src_two && !src_prev.src_two
    |=> dec_out.cmd == SSD_CMD_START_REV)
    else $error("sel3 reverse start missed");
  a_sel3_both_stop: assert property (
    clock_en && sel == SSD_SEL_FWD_REV && src.src_one == src.src_two
    |=> dec_out.cmd == SSD_CMD_STOP)
    else $error("sel3 equal sources did not stop");
  a_sel4_gate_start: assert property (
    clock_en && sel == SSD_SEL_PULSE_HOLD && src.src_two && src.src_one && !src_prev.src_one
    |=> dec_out.cmd == SSD_CMD_START_FWD)
    else $error("sel4 gated start missed");
  a_sel4_stop_hold: assert property (
    s_sel4_two_low |=> dec_out.cmd == SSD_CMD_STOP)
    else $error("sel4 source two low did not stop");
  a_sel4_no_level: assert property (
    clock_en && sel == SSD_SEL_PULSE_HOLD && dec_out.cmd == SSD_CMD_STOP
    && src.src_one && src_prev.src_one |=> dec_out.cmd == SSD_CMD_STOP)
    else $error("sel4 started on level");
  a_sel4_keys_off: assert property (
    s_sel4_two_low |=> dec_out.keys_disabled)
    else $error("sel4 keys not disabled");
  a_sel0_hold_cmd: assert property (
    clock_en && sel == SSD_SEL_NONE |=> $stable(dec_out.cmd))
    else $error("sel0 command changed");
  a_freeze_hold: assert property (
    !clock_en |=> $stable(dec_out))
    else $error("state moved without clock enable");

  // -------------------------------------------------------------------------
  // checks: trigger kinds and the pin path
  // -------------------------------------------------------------------------
  // three enabled edges are what a pin change needs to reach the registered command
  sequence s_pin_one_low3;
    (clock_en && sel == SSD_SEL_START_ONLY && !src_pins.src_one) [*3];
  endsequence

  sequence s_sel1_edge_held;
    clock_en && sel == SSD_SEL_START_ONLY && trig_level == SSD_TRIG_EDGE
    && src.src_one && src_prev.src_one;
  endsequence

  a_pin_to_stop: assert property (
    s_pin_one_low3 |=> dec_out.cmd == SSD_CMD_STOP)
    else $error("sel1 pin low did not reach stop");
  a_sel1_level_start: assert property (
    clock_en && sel == SSD_SEL_START_ONLY && trig_level == SSD_TRIG_LEVEL && src.src_one
    |=> dec_out.cmd == SSD_CMD_START_FWD)
    else $error("sel1 level start missed");
  a_sel1_edge_hold: assert property (
    s_sel1_edge_held |=> $stable(dec_out.cmd))
    else $error("sel1 held high level changed command");
  a_sel2_low_stop: assert property (
    clock_en && sel == SSD_SEL_START_DIR && !src.src_one |=> dec_out.cmd == SSD_CMD_STOP)
    else $error("sel2 low source one did not stop");
  a_sel2_level_dir: assert property (
    clock_en && sel == SSD_SEL_START_DIR && trig_level == SSD_TRIG_LEVEL && src.src_one
    |=> dec_out.cmd == ($past(src.src_two) ? SSD_CMD_START_REV : SSD_CMD_START_FWD))
    else $error("sel2 level direction wrong");
  a_sel2_dir_latched: assert property (
    clock_en && sel == SSD_SEL_START_DIR && trig_level == SSD_TRIG_EDGE
    && src.src_one && src_prev.src_one |=> $stable(dec_out.cmd))
    else $error("sel2 edge start changed without an edge");

  // -------------------------------------------------------------------------
  // checks: selections 3 and 4, unused codes
  // -------------------------------------------------------------------------
  a_sel3_fwd_start: assert property (
    clock_en && sel == SSD_SEL_FWD_REV && src.src_one && !src.src_two && !src_prev.src_one
    |=> dec_out.cmd == SSD_CMD_START_FWD)
    else $error("sel3 forward start missed");
  a_sel3_level_rev: assert property (
    clock_en && sel == SSD_SEL_FWD_REV && trig_level == SSD_TRIG_LEVEL
    && !src.src_one && src.src_two |=> dec_out.cmd == SSD_CMD_START_REV)
    else $error("sel3 level reverse start missed");
  // keys follow source two only; the trigger setting must not reach them
  a_sel4_keys_on: assert property (
    clock_en && sel == SSD_SEL_PULSE_HOLD && src.src_two |=> !dec_out.keys_disabled)
    else $error("sel4 keys disabled with source two high");
  a_keys_other_sel: assert property (
    clock_en && sel != SSD_SEL_PULSE_HOLD |=> !dec_out.keys_disabled)
    else $error("keys disabled outside sel4");
  a_sel4_level_hold: assert property (
    clock_en && sel == SSD_SEL_PULSE_HOLD && trig_level == SSD_TRIG_LEVEL
    && src.src_two && src_prev.src_one |=> $stable(dec_out.cmd))
    else $error("sel4 level trigger changed command");
  a_unused_hold: assert property (
    clock_en && sel > SSD_SEL_PULSE_HOLD |=> $stable(dec_out.cmd))
    else $error("unused selection changed command");
endmodule
`default_nettype wire

// ---- verif/ssd_src_model.sv ----
// command source pin model: holds both source pins at what it is told
// assumes the caller changes pins just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module ssd_src_model
(
  output var ssd_pkg::ssd_src_t pins
);
  import ssd_pkg::*;
  // ----
  // pin drive
  // ----
  initial pins = SSD_SRC_RESET;
  task automatic set(input ssd_src_t v);
    pins = v;
  endtask
endmodule
`default_nettype wire

// ---- verif/test_start_stop_command_decoder.sv ----
// self-checking bench: random pins and enables against a cycle model
// assumes the pin model and the package constants
`timescale 1ns/100ps
`default_nettype none
module test_start_stop_command_decoder;
  import ssd_pkg::*;
  logic clock = 0;
  logic rst_b = 0;
  logic clock_en = 1;
  ssd_sel_t sel = SSD_SEL_NONE;
  logic trig_level = 0;
  ssd_src_t src_pins;
  ssd_out_t dec_out;
  ssd_src_t st1, s, p;
  ssd_cmd_t m_cmd;
  logic m_keys, a, b, c1, c2, r1;
  ssd_out_t exp_q[$];
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  ssd_src_model i_src (.pins(src_pins));
  ssd_decoder i_dut (.clock(clock), .rst_b(rst_b), .clock_en(clock_en), .sel(sel),
    .trig_level(trig_level), .src_pins(src_pins), .dec_out(dec_out));
  initial forever #10 clock = ~clock;
  // ----
  // cycle model: two sync flops, previous sample, held command
  // ----
  assign a = s.src_one;
  assign b = s.src_two;
  assign r1 = a & !p.src_one;
  assign c1 = trig_level ? a : r1;
  assign c2 = trig_level ? b : b & !p.src_two;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      st1 <= SSD_SRC_RESET;
      s <= SSD_SRC_RESET;
      p <= SSD_SRC_RESET;
      m_cmd <= SSD_CMD_RESET;
      m_keys <= SSD_KEYS_DIS_RESET;
    end
    else if (clock_en)
    begin
      st1 <= src_pins;
      s <= st1;
      p <= s;
      m_keys <= (sel == SSD_SEL_PULSE_HOLD) && !b;
      case (sel)
        SSD_SEL_START_ONLY: m_cmd <= !a ? SSD_CMD_STOP : c1 ? SSD_CMD_START_FWD : m_cmd;
        SSD_SEL_START_DIR: m_cmd <= !a ? SSD_CMD_STOP : !c1 ? m_cmd :
          b ? SSD_CMD_START_REV : SSD_CMD_START_FWD;
        SSD_SEL_FWD_REV: m_cmd <= (a == b) ? SSD_CMD_STOP : (c1 & !b) ? SSD_CMD_START_FWD :
          (c2 & !a) ? SSD_CMD_START_REV : m_cmd;
        SSD_SEL_PULSE_HOLD: m_cmd <= !b ? SSD_CMD_STOP : r1 ? SSD_CMD_START_FWD : m_cmd;
        default: m_cmd <= m_cmd;
      endcase
    end
  // ----
  // scoreboard: note after each edge, compare at the falling edge
  // ----
  always @(posedge clock)
  begin
    #2;
    exp_q.push_back({m_cmd, m_keys});
  end
  always @(negedge clock)
    if (exp_q.size() > 0)
    begin
      ssd_out_t e;
      e = exp_q.pop_front();
      cmp_cmd(dec_out.cmd, e.cmd);
      cmp_keys(dec_out.keys_disabled, e.keys_disabled);
    end
  task automatic cmp_cmd(input ssd_cmd_t got, input ssd_cmd_t want);
    samples_checked++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t cmd got %h want %h", $time, got, want);
    end
  endtask
  task automatic cmp_keys(input logic got, input logic want);
    samples_checked++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t keys got %h want %h", $time, got, want);
    end
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // about 3200 cycles of tests; the ceiling leaves room
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  // ----
  // stimulus: every code with both trigger kinds, a reset mid-run
  // ----
  initial
  begin
    void'($urandom(13));
    repeat (2) @(posedge clock);
    #1 rst_b = 1;
    for (int t = 0; t < 16; t++)
    begin
      sel = ssd_sel_t'(t % 8);
      trig_level = (t >= 8);
      for (int k = 0; k < 200; k++)
      begin
        @(posedge clock);
        #1;
        rst_b = !(t == 5 && k >= 100 && k < 102);
        clock_en = $urandom_range(15) != 0;
        if ($urandom_range(3) == 0)
          i_src.set(ssd_src_t'(2'($urandom_range(3))));
      end
      $display("test sel %0d trig %0d done", t % 8, t / 8);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
